/* include/bcb_pkg.sv */
// Constants for the channel B break compare block
package bcb_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam int          DATA_W       = 32;
    localparam int          ADR_W        = 8;
    localparam int          COUNT_W      = 12;
    localparam logic [7:0]  OFS_CMP      = 8'h00;
    localparam logic [7:0]  OFS_MASK     = 8'h04;
    localparam logic [7:0]  OFS_CYC      = 8'h08;
    localparam logic [7:0]  OFS_CTRL     = 8'h0C;
    localparam logic [7:0]  OFS_COUNT    = 8'h10;
    localparam logic [31:0] RST_WORD     = 32'h00000000;
    localparam logic [31:0] CYC_WMASK    = 32'h000000FF;
    localparam logic [31:0] CTRL_WMASK   = 32'h00300CC9;
    localparam logic [31:0] COUNT_WMASK  = 32'h00000FFF;
    localparam logic [31:0] ALL_ONES     = 32'hFFFFFFFF;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int          CYC_MST      = 6;
    localparam int          CYC_IDS      = 4;
    localparam int          CYC_DIR      = 2;
    localparam int          CYC_SIZE     = 0;
    localparam int          CTL_ASID_A   = 21;
    localparam int          CTL_ASID_B   = 20;
    localparam int          CTL_FLAG_LO  = 12;
    localparam int          CTL_PC_TRACE_ENABLE     = 11;
    localparam int          CTL_AFTER_EXEC_SELECT_A     = 10;
    localparam int          CTL_DATA_COMPARE_ENABLE_B     = 7;
    localparam int          CTL_AFTER_EXEC_SELECT_B     = 6;
    localparam int          CTL_SEQ      = 3;
    localparam int          CTL_COUNT_BREAK_ENABLE     = 0;
    // Flag order inside the 4-bit flag group, bit 3 = cpu A
    localparam int          FLG_CPU_A    = 3;
    localparam int          FLG_CPU_B    = 2;
    localparam int          FLG_DMA_A    = 1;
    localparam int          FLG_DMA_B    = 0;
    // ****************************************
    // Encodings
    // ****************************************
    localparam logic [1:0]  SEL_OFF      = 2'h0;
    localparam logic [1:0]  MST_DMA      = 2'h2;
    localparam logic [11:0] COUNT_ONE    = 12'h001;
    localparam logic [11:0] COUNT_ZERO   = 12'h000;
endpackage

/* core/bcb_channel_b.sv */
// Channel B data, bus cycle and control compare logic with Wishbone registers
`timescale 1ns/1ps
// Functional notes
// - Compare data register 32 bits, resets zero
// - Data mask register 32 bits, resets zero
// - Clear mask bit compares, set bit excludes
// - Cycle select 8 bits, upper 24 bits zero
// - Master field: off, CPU, or DMA
// - Access field: off, fetch, data, either
// - Direction field: off, read, write, either
// - Size field: ignore, byte, word, longword
// - Control register resets zero, reserved read zero
// - Bit 21 disables channel A ASID check
// - Bit 20 selects channel B ASID use
// - Control selects independent or sequential channels
// - Break before or after fetched instruction
// - Count mode breaks after programmed matches
// - Control bit enables data bus compare
// - Match flags and PC trace enable held
// - Channel B ASID ignore bit encoding
// - Flags set by hardware, cleared writing zero
// - Sequential: channel A first, then B
// - Count decrements, breaks after reaching one
module bcb_channel_b (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        busValid,
    input  wire logic        busIsDma,
    input  wire logic        busIsFetch,
    input  wire logic        busIsWrite,
    input  wire logic [1:0]  busSize,
    input  wire logic [31:0] busData,
    input  wire logic        chanBAddrHit,
    input  wire logic        chanBAsidHit,
    input  wire logic        chanACpuHit,
    input  wire logic        chanADmaHit,
    output logic             breakReqB,
    output logic             breakAfterExecB,
    output logic             pcTraceEnable,
    output logic             afterExecSelectA,
    output logic             asidIgnoreA,
    output logic             chainedOrder
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] mergeBytes(
        input logic [31:0] oldVal,
        input logic [31:0] newVal,
        input logic [3:0]  sel,
        input logic [31:0] wmask
    );
        logic [31:0] res;
        res = oldVal;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = newVal[i*8 +: 8];
            end
        end
        return res & wmask;
    endfunction

    // Bit 0 of the select picks option one, bit 1 option two
    function automatic logic twoWayHit(
        input logic [1:0] sel,
        input logic       optOne,
        input logic       optTwo
    );
        return (sel[0] & optOne) | (sel[1] & optTwo);
    endfunction

    // ****************************************
    // Register bus
    // ****************************************
    logic [31:0] cmpDataReg;
    logic [31:0] dataMaskReg;
    logic [31:0] cycSelReg;
    logic [31:0] ctrlReg;
    logic [3:0]  flagReg;
    logic [3:0]  flagSet;
    logic [11:0] countReg;
    logic        ackReg;
    logic [31:0] rdDataReg;
    logic        armedReg;
    logic        breakReg;
    logic        afterExecReg;
    logic        busReq;
    logic        wrStrobe;
    logic [31:0] countWr;
    logic [31:0] ctrlView;
    logic [31:0] rdMux;

    assign busReq   = wb_cyc_i & wb_stb_i & ~ackReg;
    assign wrStrobe = busReq & wb_we_i;
    assign countWr  = mergeBytes({20'h00000, countReg}, wb_dat_i, wb_sel_i, bcb_pkg::COUNT_WMASK);
    assign ctrlView = ctrlReg | {16'h0000, flagReg, 12'h000};

    always_comb begin
        unique case (wb_adr_i)
            bcb_pkg::OFS_CMP:   rdMux = cmpDataReg;
            bcb_pkg::OFS_MASK:  rdMux = dataMaskReg;
            bcb_pkg::OFS_CYC:   rdMux = cycSelReg;
            bcb_pkg::OFS_CTRL:  rdMux = ctrlView;
            bcb_pkg::OFS_COUNT: rdMux = {20'h00000, countReg};
            default:            rdMux = bcb_pkg::RST_WORD;
        endcase
    end

    // Every access is acknowledged, unmapped reads return zero
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ackReg    <= 1'b0;
            rdDataReg <= bcb_pkg::RST_WORD;
        end else begin
            ackReg    <= busReq;
            if (busReq) begin
                rdDataReg <= rdMux;
            end
        end
    end

    assign wb_ack_o = ackReg;
    assign wb_dat_o = rdDataReg;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmpDataReg <= bcb_pkg::RST_WORD;
        end else if (wrStrobe && wb_adr_i == bcb_pkg::OFS_CMP) begin
            cmpDataReg <= mergeBytes(cmpDataReg, wb_dat_i, wb_sel_i, bcb_pkg::ALL_ONES);
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dataMaskReg <= bcb_pkg::RST_WORD;
        end else if (wrStrobe && wb_adr_i == bcb_pkg::OFS_MASK) begin
            dataMaskReg <= mergeBytes(dataMaskReg, wb_dat_i, wb_sel_i, bcb_pkg::ALL_ONES);
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cycSelReg <= bcb_pkg::RST_WORD;
        end else if (wrStrobe && wb_adr_i == bcb_pkg::OFS_CYC) begin
            cycSelReg <= mergeBytes(cycSelReg, wb_dat_i, wb_sel_i, bcb_pkg::CYC_WMASK);
        end
    end

    // Flags are kept apart so the write mask never touches them here
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrlReg <= bcb_pkg::RST_WORD;
        end else if (wrStrobe && wb_adr_i == bcb_pkg::OFS_CTRL) begin
            ctrlReg <= mergeBytes(ctrlReg, wb_dat_i, wb_sel_i, bcb_pkg::CTRL_WMASK);
        end
    end

    // ****************************************
    // Channel B compare
    // ****************************************
    logic [1:0] mstSel;
    logic [1:0] idSel;
    logic [1:0] dirSel;
    logic [1:0] sizeSel;
    logic       mstHit;
    logic       idHit;
    logic       dirHit;
    logic       sizeHit;
    logic       dataHit;
    logic       asidOk;
    logic       condB;
    logic       chanAHit;
    logic       seqOk;
    logic       countHit;
    logic       breakFire;

    assign mstSel  = cycSelReg[bcb_pkg::CYC_MST +: 2];
    assign idSel   = cycSelReg[bcb_pkg::CYC_IDS +: 2];
    assign dirSel  = cycSelReg[bcb_pkg::CYC_DIR +: 2];
    assign sizeSel = cycSelReg[bcb_pkg::CYC_SIZE +: 2];

    assign mstHit  = (mstSel[0] & ~busIsDma)
                   | ((mstSel == bcb_pkg::MST_DMA) & busIsDma);
    assign idHit   = twoWayHit(idSel, busIsFetch, ~busIsFetch);
    assign dirHit  = twoWayHit(dirSel, ~busIsWrite, busIsWrite);
    // Size is checked on every cycle, whether or not the data compare is enabled
    assign sizeHit = (sizeSel == bcb_pkg::SEL_OFF) | (sizeSel == busSize);
    assign dataHit = ~ctrlReg[bcb_pkg::CTL_DATA_COMPARE_ENABLE_B]
                   | (((busData ^ cmpDataReg) & ~dataMaskReg) == bcb_pkg::RST_WORD);
    assign asidOk  = ctrlReg[bcb_pkg::CTL_ASID_B] | chanBAsidHit;
    assign condB   = busValid & mstHit & idHit & dirHit & sizeHit
                   & dataHit & chanBAddrHit & asidOk;

    assign chanAHit = chanACpuHit | chanADmaHit;

    // ****************************************
    // Match flags
    // ****************************************
    assign flagSet = {chanACpuHit, condB & ~busIsDma, chanADmaHit, condB & busIsDma};

    // Writing one leaves a flag alone; a set in the clear cycle wins
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            flagReg <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (flagSet[i]) begin
                    flagReg[i] <= 1'b1;
                end else if (wrStrobe && wb_adr_i == bcb_pkg::OFS_CTRL && wb_sel_i[1]
                             && !wb_dat_i[bcb_pkg::CTL_FLAG_LO + i]) begin
                    flagReg[i] <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Sequence and count
    // ****************************************
    // Armed once channel A matches, consumed by the channel B break
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            armedReg <= 1'b0;
        end else if (!ctrlReg[bcb_pkg::CTL_SEQ]) begin
            armedReg <= 1'b0;
        end else if (chanAHit) begin
            armedReg <= 1'b1;
        end else if (breakFire) begin
            armedReg <= 1'b0;
        end
    end

    assign seqOk     = ~ctrlReg[bcb_pkg::CTL_SEQ] | armedReg;
    // A count of zero behaves as already reached
    assign countHit  = ~ctrlReg[bcb_pkg::CTL_COUNT_BREAK_ENABLE] | (countReg <= bcb_pkg::COUNT_ONE);
    assign breakFire = condB & seqOk & countHit;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            countReg <= bcb_pkg::COUNT_ZERO;
        end else if (wrStrobe && wb_adr_i == bcb_pkg::OFS_COUNT) begin
            countReg <= countWr[11:0];
        end else if (ctrlReg[bcb_pkg::CTL_COUNT_BREAK_ENABLE] && condB && seqOk
                     && countReg != bcb_pkg::COUNT_ZERO) begin
            countReg <= countReg - bcb_pkg::COUNT_ONE;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            breakReg     <= 1'b0;
            afterExecReg <= 1'b0;
        end else begin
            breakReg     <= breakFire;
            afterExecReg <= breakFire & busIsFetch & ctrlReg[bcb_pkg::CTL_AFTER_EXEC_SELECT_B];
        end
    end

    assign breakReqB        = breakReg;
    assign breakAfterExecB  = afterExecReg;
    assign pcTraceEnable    = ctrlReg[bcb_pkg::CTL_PC_TRACE_ENABLE];
    assign afterExecSelectA = ctrlReg[bcb_pkg::CTL_AFTER_EXEC_SELECT_A];
    assign asidIgnoreA      = ctrlReg[bcb_pkg::CTL_ASID_A];
    assign chainedOrder     = ctrlReg[bcb_pkg::CTL_SEQ];

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cbClk @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence sReq;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence sCountStep;
        ctrlReg[bcb_pkg::CTL_COUNT_BREAK_ENABLE] && condB && seqOk && countReg > bcb_pkg::COUNT_ONE
            && !(wrStrobe && wb_adr_i == bcb_pkg::OFS_COUNT);
    endsequence

    localparam int FLAG_B = bcb_pkg::FLG_CPU_B;

    sequence sFlagHold;
        flagReg[FLAG_B] && !(wrStrobe && wb_adr_i == bcb_pkg::OFS_CTRL && wb_sel_i[1]);
    endsequence

    AST_WB_ACK: assert property (sReq |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle after request");
    AST_CYC_RSVD: assert property (cycSelReg[31:8] == 24'h000000)
        else $error("cycle select upper bits not zero");
    AST_CTRL_RSVD: assert property ((ctrlView & ~bcb_pkg::CTRL_WMASK & 32'hFFFF0FFF) == 32'h0)
        else $error("control reserved bits not zero");
    AST_MASK_ALL: assert property (dataMaskReg == bcb_pkg::ALL_ONES |-> dataHit)
        else $error("fully masked data failed to match");
    AST_FIELD_OFF: assert property ((mstSel == bcb_pkg::SEL_OFF || idSel == bcb_pkg::SEL_OFF
                                    || dirSel == bcb_pkg::SEL_OFF) |-> !condB)
        else $error("disabled field still matched");
    AST_SIZE_MISS: assert property ((sizeSel != bcb_pkg::SEL_OFF && busSize != sizeSel)
                                   |-> !condB)
        else $error("size mismatch still matched");
    AST_ASID_B: assert property ((!ctrlReg[bcb_pkg::CTL_ASID_B] && !chanBAsidHit) |-> !condB)
        else $error("channel B matched without ASID");
    AST_FLAG_SET: assert property ((condB && !busIsDma) |=> flagReg[bcb_pkg::FLG_CPU_B])
        else $error("cpu flag B not set on match");
    AST_FLAG_HOLD: assert property (sFlagHold |=> flagReg[FLAG_B])
        else $error("flag cleared without a write");
    AST_SEQ_WAIT: assert property ((ctrlReg[bcb_pkg::CTL_SEQ] && !armedReg) |=> !breakReqB)
        else $error("sequential break without channel A");
    AST_COUNT_DEC: assert property (sCountStep |=> (countReg == $past(countReg) - 12'h001)
                                   && !breakReqB)
        else $error("count did not step or broke early");
endmodule

/* bench/bcb_bus_model.sv */
// Model of the observed processor and DMA bus cycles
`timescale 1ns/1ps
module bcb_bus_model (
    input  wire logic        core_clk,
    output logic             busValid,
    output logic             busIsDma,
    output logic             busIsFetch,
    output logic             busIsWrite,
    output logic      [1:0]  busSize,
    output logic      [31:0] busData,
    output logic             chanBAddrHit,
    output logic             chanBAsidHit,
    output logic             chanACpuHit,
    output logic             chanADmaHit
);
    initial begin
        {busValid, busIsDma, busIsFetch, busIsWrite, busSize} = 6'h00;
        {chanBAddrHit, chanBAsidHit, chanACpuHit, chanADmaHit} = 4'h0;
        busData = 32'h00000000;
    end
    // a: dma, fetch, write, size, addr hit, asid hit, A cpu hit, A dma hit
    task automatic send(input logic v, input logic [8:0] a, input logic [31:0] d);
        @(posedge core_clk);
        busValid <= v;
        {busIsDma, busIsFetch, busIsWrite, busSize} <= a[8:4];
        {chanBAddrHit, chanBAsidHit, chanACpuHit, chanADmaHit} <= a[3:0];
        busData <= d;
        @(posedge core_clk);
        busValid <= 1'b0;
        {chanBAddrHit, chanBAsidHit, chanACpuHit, chanADmaHit} <= 4'h0;
        // Stale data is inverted so a leftover value can never fake a match
        busData <= ~d;
    endtask
endmodule

/* bench/bcb_channel_b_tb_top.sv */
// Self-checking bench for the channel B break compare block
`timescale 1ns/1ps
module bcb_channel_b_tb_top;
    logic        core_clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, busData, cmpV, maskV, ctl, q, r, d;
    logic        busValid, busIsDma, busIsFetch, busIsWrite, bA, bB, bC, bD;
    logic        breakReqB, breakAfterExecB, pc_trace_enable, aeA, aiA, chO, e;
    logic [1:0]  busSize;
    logic [7:0]  cs;
    logic [8:0]  at;
    int          fail_count, cmp_count;
    bcb_channel_b dut_u (.core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busValid(busValid),
        .busIsDma(busIsDma), .busIsFetch(busIsFetch), .busIsWrite(busIsWrite),
        .busSize(busSize), .busData(busData), .chanBAddrHit(bA), .chanBAsidHit(bB),
        .chanACpuHit(bC), .chanADmaHit(bD), .breakReqB(breakReqB),
        .breakAfterExecB(breakAfterExecB), .pcTraceEnable(pc_trace_enable), .afterExecSelectA(aeA),
        .asidIgnoreA(aiA), .chainedOrder(chO));
    bcb_bus_model bus_u (.core_clk(core_clk), .busValid(busValid), .busIsDma(busIsDma),
        .busIsFetch(busIsFetch), .busIsWrite(busIsWrite), .busSize(busSize),
        .busData(busData), .chanBAddrHit(bA), .chanBAsidHit(bB), .chanACpuHit(bC),
        .chanADmaHit(bD));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic hit(input logic [7:0] c, input logic [31:0] k, input logic [8:0] a,
                                 input logic [31:0] x);
        logic m;
        m = a[8] ? (c[7:6] == 2'h2) : c[6];
        m = m && (a[7] ? c[4] : c[5]) && (a[6] ? c[3] : c[2]);
        m = m && ((c[1:0] == 2'h0) || (c[1:0] == a[5:4]));
        m = m && (!k[7] || (((x ^ cmpV) & ~maskV) == 32'h00000000));
        return m && a[3] && (k[20] || a[2]);
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    // Single classic cycle; the wait is bounded so a dead slave cannot hang the run
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] x);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= x;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            stop_test;
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
        wb(1'b0, a, 32'h00000000);
        chk(q, x);
    endtask
    task automatic brk(input logic v, input logic [8:0] a, input logic [31:0] x,
                       input logic ex);
        bus_u.send(v, a, x);
        @(posedge core_clk);
        chk({31'h0, breakReqB}, {31'h0, ex});
    endtask
    task automatic stop_test;
        $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        repeat (50000) @(posedge core_clk);
        fail_count++;
        stop_test;
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        {arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 4'hF;
        r = 32'h00013376;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        for (int a = 0; a < 6; a++) rdchk(8'(a * 4), 32'h00000000);
        $display("reset values done");
        r = lfsr(r);
        wb(1'b1, bcb_pkg::OFS_CMP, r);
        rdchk(bcb_pkg::OFS_CMP, r);
        wb(1'b1, bcb_pkg::OFS_MASK, ~r);
        rdchk(bcb_pkg::OFS_MASK, ~r);
        wb(1'b1, bcb_pkg::OFS_CYC, 32'hFFFFFFFF);
        rdchk(bcb_pkg::OFS_CYC, 32'h000000FF);
        wb(1'b1, bcb_pkg::OFS_CTRL, 32'hFFFF0FFF);
        rdchk(bcb_pkg::OFS_CTRL, 32'h00300CC9);
        chk({28'h0, pc_trace_enable, aeA, aiA, chO}, 32'h0000000F);
        wb(1'b1, 8'h20, r);
        rdchk(8'h20, 32'h00000000);
        $display("register access done");
        for (int i = 0; i < 60; i++) begin
            r = lfsr(r);
            cmpV = r;
            r = lfsr(r);
            maskV = r & lfsr(r);
            r = lfsr(r);
            cs = r[15:8];
            ctl = r & 32'h001000C0;
            at = {r[24:18], 2'h0};
            if (at[5:4] == 2'h0) at[5:4] = 2'h3;
            at[3] = r[25] | r[26];
            if (ctl[7] && cs[1:0] == 2'h0) cs[1:0] = at[5:4];
            if (cs[1:0] == 2'h1) cmpV[15:8] = cmpV[7:0];
            r = lfsr(r);
            d = cmpV ^ (r & maskV) ^ ((r[31] & r[30]) ? 32'h00000001 << r[4:0] : 32'h0);
            e = hit(cs, ctl, at, d);
            wb(1'b1, bcb_pkg::OFS_CMP, cmpV);
            wb(1'b1, bcb_pkg::OFS_MASK, maskV);
            wb(1'b1, bcb_pkg::OFS_CYC, {24'h0, cs});
            wb(1'b1, bcb_pkg::OFS_CTRL, ctl);
            bus_u.send(1'b1, at, d);
            @(posedge core_clk);
            chk({breakReqB, breakAfterExecB}, {e, e & at[7] & ctl[6]});
            rdchk(bcb_pkg::OFS_CTRL, ctl | {e & ~at[8], 1'b0, e & at[8], 12'h0});
        end
        $display("random compare done");
        wb(1'b1, bcb_pkg::OFS_CYC, 32'h00000057);
        wb(1'b1, bcb_pkg::OFS_CTRL, 32'h00000008);
        brk(1'b1, 9'h0BC, r, 1'b0);
        brk(1'b0, 9'h002, r, 1'b0);
        brk(1'b1, 9'h0BC, r, 1'b1);
        brk(1'b1, 9'h0BC, r, 1'b0);
        wb(1'b1, bcb_pkg::OFS_CTRL, 32'h0000F008);
        rdchk(bcb_pkg::OFS_CTRL, 32'h0000C008);
        $display("sequence done");
        wb(1'b1, bcb_pkg::OFS_CTRL, 32'h00000001);
        wb(1'b1, bcb_pkg::OFS_COUNT, 32'h00000003);
        for (int k = 0; k < 3; k++) begin
            brk(1'b1, 9'h0BC, r, k == 2);
            rdchk(bcb_pkg::OFS_COUNT, 32'(2 - k));
        end
        $display("count mode done");
        stop_test;
    end
endmodule
